// ### pkg/nvc_pkg.sv
// Constants and types shared by the nonvolatile access controller and its core-side end
// Functional notes
// - Software loads address and data before writing
// - Write starts only after 55h, AAh, strobe
// - Write strobe refused unless write enable set
// - Hardware never clears the write enable bit
// - Clearing write enable never aborts running write
// - Completion clears strobe and sets complete flag
// - Complete flag stays set until software clears
// - Software should mask interrupts during unlock
// - Software keeps write enable clear when idle
// - Program read: load address, select, strobe
// - Second instruction after program read ignored
// - Program word lands in data registers next cycle
// - Data registers hold until next read or write
// - Two idle slots follow a program read
// - Write strobe with program select self-clears
// - No data write without write enable
// - Strobe only set by software, cleared by hardware
package nvc_pkg;

	// Register indices on the core access port
	localparam logic [2:0] IDX_ADDR_LOW   = 3'h0;
	localparam logic [2:0] IDX_ADDR_HIGH  = 3'h1;
	localparam logic [2:0] IDX_DATA_LOW   = 3'h2;
	localparam logic [2:0] IDX_DATA_HIGH  = 3'h3;
	localparam logic [2:0] IDX_CONTROL    = 3'h4;
	localparam logic [2:0] IDX_UNLOCK_KEY = 3'h5;
	localparam logic [2:0] IDX_STATUS     = 3'h6;

	// Control and status register bit positions
	localparam int CTL_PGM_SEL = 7;
	localparam int CTL_WRITE_ENABLE = 2;
	localparam int CTL_WR      = 1;
	localparam int CTL_RD      = 0;
	localparam int STS_DONE    = 0;

	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	localparam int ADDR_HIGH_W = 5;
	localparam int DATA_HIGH_W = 6;
	localparam int FLASH_W     = 14;
	localparam int FLASH_AW    = 13;
	localparam int EE_DEPTH    = 256;
	localparam int FLASH_DEPTH = 8192;

	// Programming interval, least time so it rounds up
	localparam int CLK_PERIOD_NS = 100;
	localparam int PROG_TIME_NS  = 100000;
	localparam int PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CNT_W    = 16;

	localparam int NOP_SLOTS = 2;

	// Core-side APB map
	localparam logic [11:0] APB_CMD    = 12'h000;
	localparam logic [11:0] APB_STATUS = 12'h004;
	localparam int CMD_WRITE_BIT = 16;
	localparam int CMD_ADDR_LSB  = 8;
	localparam int HST_BUSY      = 0;
	localparam int HST_DONE      = 1;
	localparam int HST_PROG      = 2;
	localparam int HST_RDATA_LSB = 8;

	typedef enum logic [2:0] {
		NVC_KEY_IDLE  = 3'b001,
		NVC_KEY_GOT1  = 3'b010,
		NVC_KEY_ARMED = 3'b100
	} nvc_key_t;

	typedef enum logic [3:0] {
		NVC_H_IDLE  = 4'b0001,
		NVC_H_ISSUE = 4'b0010,
		NVC_H_WAIT  = 4'b0100,
		NVC_H_GAP   = 4'b1000
	} nvc_host_st_t;

endpackage

// ### pkg/nvc_if.sv
// Core access port between the processor end and the nonvolatile controller
`timescale 1ns/1ps
interface nvc_if;
	logic       acc_valid;
	logic       acc_write;
	logic [2:0] acc_addr;
	logic [7:0] acc_wdata;
	logic [7:0] acc_rdata;
	logic       acc_rvalid;
	logic       hold;
	logic       write_complete_flag;
	logic       write_busy;

	modport dev (
		input  acc_valid,
		input  acc_write,
		input  acc_addr,
		input  acc_wdata,
		output acc_rdata,
		output acc_rvalid,
		output hold,
		output write_complete_flag,
		output write_busy
	);

	modport core (
		output acc_valid,
		output acc_write,
		output acc_addr,
		output acc_wdata,
		input  acc_rdata,
		input  acc_rvalid,
		input  hold,
		input  write_complete_flag,
		input  write_busy
	);
endinterface

// ### verilog/nvc_device.sv
// Data EEPROM write and flash program read controller
`timescale 1ns/1ps
module nvc_device (
	input  wire logic                              clk,
	input  wire logic                              reset_n,
	nvc_if.dev                                     bus,
	input  wire logic                              flash_load_valid,
	input  wire logic [nvc_pkg::FLASH_AW-1:0]      flash_load_addr,
	input  wire logic [nvc_pkg::FLASH_W-1:0]       flash_load_word
);

	typedef struct packed {
		logic [7:0]                          addr_low;
		logic [nvc_pkg::ADDR_HIGH_W-1:0]     addr_high;
		logic [7:0]                          data_low;
		logic [nvc_pkg::DATA_HIGH_W-1:0]     data_high;
		logic                                pgm_sel;
		logic                                write_enable_bit;
		logic                                wr;
		nvc_pkg::nvc_key_t                   key;
		logic [nvc_pkg::PROG_CNT_W-1:0]      prog_cnt;
		logic [7:0]                          prog_addr;
		logic [7:0]                          prog_data;
		logic                                prog_commit;
		logic                                done;
		logic [1:0]                          hold_pipe;
		logic [7:0]                          rdata;
		logic                                rvalid;
	} nvc_dev_state_t;

	nvc_dev_state_t st;
	nvc_dev_state_t next_st;

	logic [7:0]                    ee_mem [nvc_pkg::EE_DEPTH];
	logic [nvc_pkg::FLASH_W-1:0]   flash_mem [nvc_pkg::FLASH_DEPTH];

	logic                          acc_take;
	logic                          wr_take;
	logic [nvc_pkg::FLASH_AW-1:0]  flash_addr;
	logic [nvc_pkg::FLASH_W-1:0]   flash_word;

	localparam logic [nvc_pkg::PROG_CNT_W-1:0] PROG_LAST =
		nvc_pkg::PROG_CNT_W'(nvc_pkg::PROG_CYCLES - 1);

	// Next step of the unlock sequence for one write
	function automatic nvc_pkg::nvc_key_t key_step(
		input nvc_pkg::nvc_key_t cur,
		input logic              to_key,
		input logic [7:0]        val
	);
		nvc_pkg::nvc_key_t res;
		res = nvc_pkg::NVC_KEY_IDLE;
		if (to_key && val == nvc_pkg::KEY_FIRST) begin
			res = nvc_pkg::NVC_KEY_GOT1;
		end else if (to_key && val == nvc_pkg::KEY_SECOND && cur == nvc_pkg::NVC_KEY_GOT1) begin
			res = nvc_pkg::NVC_KEY_ARMED;
		end
		return res;
	endfunction

	// Accesses in the flash fetch slot are dropped, as the core ignores that instruction
	assign acc_take   = bus.acc_valid && !st.hold_pipe[1];
	assign flash_addr = {st.addr_high, st.addr_low};
	assign flash_word = flash_mem[flash_addr];

	// Strobe is accepted only after the key pair, with enable already set and data selected
	assign wr_take = acc_take && bus.acc_write && bus.acc_addr == nvc_pkg::IDX_CONTROL
		&& bus.acc_wdata[nvc_pkg::CTL_WR]
		&& st.key == nvc_pkg::NVC_KEY_ARMED
		&& st.write_enable_bit
		&& !bus.acc_wdata[nvc_pkg::CTL_PGM_SEL]
		&& !st.wr;

	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		next_st.prog_commit = 1'b0;
		next_st.hold_pipe = {st.hold_pipe[0], 1'b0};

		if (acc_take && bus.acc_write) begin
			// Any write other than the next key step breaks the sequence
			next_st.key = key_step(st.key, bus.acc_addr == nvc_pkg::IDX_UNLOCK_KEY,
				bus.acc_wdata);
			case (bus.acc_addr)
				nvc_pkg::IDX_ADDR_LOW: begin
					next_st.addr_low = bus.acc_wdata;
				end
				nvc_pkg::IDX_ADDR_HIGH: begin
					next_st.addr_high = bus.acc_wdata[nvc_pkg::ADDR_HIGH_W-1:0];
				end
				nvc_pkg::IDX_DATA_LOW: begin
					next_st.data_low = bus.acc_wdata;
				end
				nvc_pkg::IDX_DATA_HIGH: begin
					next_st.data_high = bus.acc_wdata[nvc_pkg::DATA_HIGH_W-1:0];
				end
				nvc_pkg::IDX_CONTROL: begin
					next_st.pgm_sel = bus.acc_wdata[nvc_pkg::CTL_PGM_SEL];
					// Only software moves the enable; a running write no longer looks at it
					next_st.write_enable_bit = bus.acc_wdata[nvc_pkg::CTL_WRITE_ENABLE];
					if (wr_take) begin
						// Latch target so later register writes cannot disturb the cycle
						next_st.wr = 1'b1;
						next_st.prog_cnt = '0;
						next_st.prog_addr = st.addr_low;
						next_st.prog_data = st.data_low;
					end
					if (bus.acc_wdata[nvc_pkg::CTL_RD]) begin
						if (bus.acc_wdata[nvc_pkg::CTL_PGM_SEL]) begin
							next_st.data_low = flash_word[7:0];
							next_st.data_high = flash_word[nvc_pkg::FLASH_W-1:8];
							next_st.hold_pipe[0] = 1'b1;
						end else begin
							next_st.data_low = ee_mem[st.addr_low];
						end
					end
				end
				nvc_pkg::IDX_STATUS: begin
					if (!bus.acc_wdata[nvc_pkg::STS_DONE]) begin
						next_st.done = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		if (acc_take && !bus.acc_write) begin
			next_st.rvalid = 1'b1;
			case (bus.acc_addr)
				nvc_pkg::IDX_ADDR_LOW: begin
					next_st.rdata = st.addr_low;
				end
				nvc_pkg::IDX_ADDR_HIGH: begin
					next_st.rdata = 8'(st.addr_high);
				end
				nvc_pkg::IDX_DATA_LOW: begin
					next_st.rdata = st.data_low;
				end
				nvc_pkg::IDX_DATA_HIGH: begin
					next_st.rdata = 8'(st.data_high);
				end
				nvc_pkg::IDX_CONTROL: begin
					next_st.rdata = 8'h00;
					next_st.rdata[nvc_pkg::CTL_PGM_SEL] = st.pgm_sel;
					next_st.rdata[nvc_pkg::CTL_WRITE_ENABLE] = st.write_enable_bit;
					next_st.rdata[nvc_pkg::CTL_WR] = st.wr;
				end
				nvc_pkg::IDX_STATUS: begin
					next_st.rdata = 8'h00;
					next_st.rdata[nvc_pkg::STS_DONE] = st.done;
				end
				default: begin
					next_st.rdata = 8'h00;
				end
			endcase
		end

		// Programming interval; completion is placed last so its set beats a clear
		if (st.wr) begin
			if (st.prog_cnt == PROG_LAST) begin
				next_st.wr = 1'b0;
				next_st.done = 1'b1;
				next_st.prog_commit = 1'b1;
			end else begin
				next_st.prog_cnt = st.prog_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st <= '0;
			st.key <= nvc_pkg::NVC_KEY_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Cell array updated at the end of the interval, after the strobe has been held
	always_ff @(posedge clk) begin
		if (st.prog_commit) begin
			ee_mem[st.prog_addr] <= st.prog_data;
		end
	end

	// Program array is filled from outside, as the block writes are not supported here
	always_ff @(posedge clk) begin
		if (flash_load_valid) begin
			flash_mem[flash_load_addr] <= flash_load_word;
		end
	end

	assign bus.acc_rdata           = st.rdata;
	assign bus.acc_rvalid          = st.rvalid;
	assign bus.hold                = st.hold_pipe[1];
	assign bus.write_complete_flag = st.done;
	assign bus.write_busy          = st.wr;

endmodule // nvc_device

// ### verilog/nvc_core_end.sv
// Processor-side end: turns APB commands into register accesses on the core port
`timescale 1ns/1ps
module nvc_core_end (
	input  wire logic         clk,
	input  wire logic         reset_n,
	nvc_if.core               bus,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr
);

	typedef struct packed {
		nvc_pkg::nvc_host_st_t  state;
		logic                   acc_valid;
		logic                   acc_write;
		logic [2:0]             acc_addr;
		logic [7:0]             acc_wdata;
		logic [7:0]             last_rdata;
		logic                   flash_read;
		logic [1:0]             gap_cnt;
		logic                   done;
		logic                   prog;
		logic [31:0]            prdata;
		logic                   pready;
	} nvc_core_state_t;

	nvc_core_state_t st;
	nvc_core_state_t next_st;

	logic setup;
	logic access_end;

	assign setup      = psel && !penable;
	assign access_end = psel && penable && st.pready;

	always_comb begin
		next_st = st;
		next_st.pready = 1'b0;
		next_st.done = bus.write_complete_flag;
		next_st.prog = bus.write_busy;

		// One-cycle answer: pready rises in the access phase after every setup
		if (setup) begin
			next_st.pready = 1'b1;
			next_st.prdata = 32'h0000_0000;
			if (!pwrite && paddr == nvc_pkg::APB_STATUS) begin
				next_st.prdata[nvc_pkg::HST_BUSY] = st.state != nvc_pkg::NVC_H_IDLE;
				next_st.prdata[nvc_pkg::HST_DONE] = st.done;
				next_st.prdata[nvc_pkg::HST_PROG] = st.prog;
				next_st.prdata[nvc_pkg::HST_RDATA_LSB +: 8] = st.last_rdata;
			end
		end

		// Command taken only at the completing edge, where the request is final
		// Commands taken while idle are forwarded in order and untouched; one arriving while not idle is dropped
		if (access_end && pwrite && paddr == nvc_pkg::APB_CMD
			&& st.state == nvc_pkg::NVC_H_IDLE) begin
			next_st.state = nvc_pkg::NVC_H_ISSUE;
			next_st.acc_valid = 1'b1;
			next_st.acc_write = pwdata[nvc_pkg::CMD_WRITE_BIT];
			next_st.acc_addr = pwdata[nvc_pkg::CMD_ADDR_LSB +: 3];
			next_st.acc_wdata = pwdata[7:0];
			next_st.flash_read = pwdata[nvc_pkg::CMD_WRITE_BIT]
				&& pwdata[nvc_pkg::CMD_ADDR_LSB +: 3] == nvc_pkg::IDX_CONTROL
				&& pwdata[nvc_pkg::CTL_RD] && pwdata[nvc_pkg::CTL_PGM_SEL];
		end

		case (st.state)
			nvc_pkg::NVC_H_IDLE: begin
			end
			nvc_pkg::NVC_H_ISSUE: begin
				// A held slot would be dropped by the device, so retry it
				if (!bus.hold) begin
					next_st.acc_valid = 1'b0;
					if (!st.acc_write) begin
						next_st.state = nvc_pkg::NVC_H_WAIT;
					end else if (st.flash_read) begin
						next_st.state = nvc_pkg::NVC_H_GAP;
						next_st.gap_cnt = 2'(nvc_pkg::NOP_SLOTS - 1);
					end else begin
						next_st.state = nvc_pkg::NVC_H_IDLE;
					end
				end
			end
			nvc_pkg::NVC_H_WAIT: begin
				if (bus.acc_rvalid) begin
					next_st.last_rdata = bus.acc_rdata;
					next_st.state = nvc_pkg::NVC_H_IDLE;
				end
			end
			nvc_pkg::NVC_H_GAP: begin
				// Idle slots after a flash read, covering the ignored one
				if (st.gap_cnt == 2'h0) begin
					next_st.state = nvc_pkg::NVC_H_IDLE;
				end else begin
					next_st.gap_cnt = st.gap_cnt - 2'h1;
				end
			end
			default: begin
				next_st.state = nvc_pkg::NVC_H_IDLE;
				next_st.acc_valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st <= '0;
			st.state <= nvc_pkg::NVC_H_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign bus.acc_valid = st.acc_valid;
	assign bus.acc_write = st.acc_write;
	assign bus.acc_addr  = st.acc_addr;
	assign bus.acc_wdata = st.acc_wdata;
	assign prdata        = st.prdata;
	assign pready        = st.pready;
	assign pslverr       = 1'b0;

endmodule // nvc_core_end

// ### dv/nvc_sva.sv
// Checker on the core port between the processor end and the controller
`timescale 1ns/1ps
module nvc_sva (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       acc_valid,
	input wire logic       acc_write,
	input wire logic [2:0] acc_addr,
	input wire logic [7:0] acc_wdata,
	input wire logic       acc_rvalid,
	input wire logic       hold,
	input wire logic       write_complete_flag,
	input wire logic       write_busy
);
	logic [15:0] busy_cnt;
	logic        ctl_wr;
	logic        pgm_rd;
	logic        ee_strobe;
	logic        pgm_strobe;
	logic        done_clr;

	assign ctl_wr     = acc_valid && acc_write && !hold && acc_addr == nvc_pkg::IDX_CONTROL;
	assign pgm_rd     = ctl_wr && acc_wdata[nvc_pkg::CTL_PGM_SEL] && acc_wdata[nvc_pkg::CTL_RD];
	assign ee_strobe  = ctl_wr && acc_wdata[nvc_pkg::CTL_WR] && !acc_wdata[nvc_pkg::CTL_PGM_SEL];
	assign pgm_strobe = ctl_wr && acc_wdata[nvc_pkg::CTL_WR] && acc_wdata[nvc_pkg::CTL_PGM_SEL];
	assign done_clr   = acc_valid && acc_write && acc_addr == nvc_pkg::IDX_STATUS
		&& !acc_wdata[nvc_pkg::STS_DONE];

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Length of the busy level, so the programming interval can be bounded exactly
	always_ff @(posedge clk) begin
		if (!reset_n)
			busy_cnt <= 16'h0;
		else
			busy_cnt <= write_busy ? busy_cnt + 16'h1 : 16'h0;
	end

	sequence s_pgm_rd;
		pgm_rd;
	endsequence
	sequence s_gap;
		!hold ##1 hold;
	endsequence

	property p_start;
		$rose(write_busy) |-> $past(ee_strobe);
	endproperty
	a_start: assert property (p_start) else $error("write began without strobe");
	property p_pgm_nop;
		pgm_strobe && !write_busy |=> !write_busy;
	endproperty
	a_pgm_nop: assert property (p_pgm_nop) else $error("strobe with program select ran");
	property p_prog_len;
		$fell(write_busy) |-> busy_cnt == 16'(nvc_pkg::PROG_CYCLES);
	endproperty
	a_prog_len: assert property (p_prog_len) else $error("programming length wrong");
	property p_done;
		$fell(write_busy) |-> write_complete_flag;
	endproperty
	a_done: assert property (p_done) else $error("no flag at completion");
	property p_flag_cause;
		$rose(write_complete_flag) |-> $fell(write_busy);
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag without completion");
	property p_sticky;
		write_complete_flag && !done_clr |=> write_complete_flag;
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag cleared by itself");
	property p_write_enable_bit_clear;
		write_busy && ctl_wr && !acc_wdata[nvc_pkg::CTL_WRITE_ENABLE] |=>
			write_busy || write_complete_flag;
	endproperty
	a_write_enable_bit_clear: assert property (p_write_enable_bit_clear) else $error("write aborted");
	property p_hold_slot;
		s_pgm_rd |=> s_gap;
	endproperty
	a_hold_slot: assert property (p_hold_slot) else $error("hold not in second slot");
	property p_hold_cause;
		$rose(hold) |-> $past(pgm_rd, 2);
	endproperty
	a_hold_cause: assert property (p_hold_cause) else $error("hold without read");
	property p_rd_ans;
		acc_valid && !acc_write && !hold |=> acc_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
endmodule // nvc_sva

// ### dv/tb_eeprom_write_flash_read_ctrl.sv
// Bench driving both ends through APB and judging the core port
`timescale 1ns/1ps
module tb_eeprom_write_flash_read_ctrl;
	logic        clk;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        fl_valid;
	logic [12:0] fl_addr;
	logic [13:0] fl_word;
	int          num_errors;
	int          checks;

	nvc_if bus_if ();
	nvc_device u_nvc_device (.clk(clk), .reset_n(reset_n), .bus(bus_if),
		.flash_load_valid(fl_valid), .flash_load_addr(fl_addr), .flash_load_word(fl_word));
	nvc_core_end u_nvc_core_end (.clk(clk), .reset_n(reset_n), .bus(bus_if), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	nvc_sva u_nvc_sva (.clk(clk), .reset_n(reset_n), .acc_valid(bus_if.acc_valid),
		.acc_write(bus_if.acc_write), .acc_addr(bus_if.acc_addr),
		.acc_wdata(bus_if.acc_wdata), .acc_rvalid(bus_if.acc_rvalid), .hold(bus_if.hold),
		.write_complete_flag(bus_if.write_complete_flag), .write_busy(bus_if.write_busy));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task wrap_up;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task fail_to(input string what);
		num_errors++;
		$display("[FAIL] %0t %s timed out", $time, what);
		wrap_up();
	endtask

	// Entered just after a rising edge; leaves one idle edge so no signal is driven twice
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			fail_to("apb");
		@(posedge clk);
	endtask

	task idle(output logic [31:0] q);
		int n;
		for (n = 0; n < 20; n++) begin
			apb(1'b0, 12'h004, 32'h0, q);
			if (q[0] === 1'b0)
				break;
		end
		if (n == 20)
			fail_to("idle");
	endtask

	task wr(input logic [2:0] i, input logic [7:0] d);
		logic [31:0] q;
		apb(1'b1, 12'h000, {15'h0, 1'b1, 5'h0, i, d}, q);
		idle(q);
	endtask

	task rd(input logic [2:0] i, output logic [7:0] d);
		logic [31:0] q;
		apb(1'b1, 12'h000, {15'h0, 1'b0, 5'h0, i, 8'h0}, q);
		idle(q);
		d = q[15:8];
	endtask

	task t_write;
		logic [7:0]  d;
		logic [31:0] q;
		int          n;
		wr(3'h0, 8'h12);
		wr(3'h2, 8'h5a);
		wr(3'h4, 8'h04);
		wr(3'h5, 8'h55);
		wr(3'h5, 8'haa);
		wr(3'h4, 8'h06);
		chk(bus_if.write_busy, 1'b1);
		wr(3'h4, 8'h00);
		chk(bus_if.write_busy, 1'b1);
		rd(3'h4, d);
		chk(d, 8'h02);
		chk(bus_if.write_complete_flag, 1'b0);
		apb(1'b0, 12'h004, 32'h0, q);
		chk(q[2:0], 3'b100);
		for (n = 0; n < 1200 && bus_if.write_busy === 1'b1; n++)
			@(posedge clk);
		if (n == 1200)
			fail_to("programming");
		chk(bus_if.write_complete_flag, 1'b1);
		apb(1'b0, 12'h004, 32'h0, q);
		chk(q[2:0], 3'b010);
		rd(3'h4, d);
		chk(d, 8'h00);
		wr(3'h2, 8'h00);
		wr(3'h4, 8'h01);
		rd(3'h2, d);
		chk(d, 8'h5a);
		repeat (50) @(posedge clk);
		chk(bus_if.write_complete_flag, 1'b1);
		wr(3'h6, 8'h00);
		chk(bus_if.write_complete_flag, 1'b0);
	endtask

	// Each row: control before, two key bytes, strobe write, control read back
	task t_refuse;
		logic [7:0] tv [3][5];
		logic [7:0] d;
		tv = '{'{8'h00, 8'h55, 8'haa, 8'h02, 8'h00}, '{8'h04, 8'haa, 8'h55, 8'h06, 8'h04},
			'{8'h04, 8'h55, 8'haa, 8'h86, 8'h84}};
		for (int i = 0; i < 3; i++) begin
			wr(3'h4, tv[i][0]);
			wr(3'h5, tv[i][1]);
			wr(3'h5, tv[i][2]);
			wr(3'h4, tv[i][3]);
			chk(bus_if.write_busy, 1'b0);
			rd(3'h4, d);
			chk(d, tv[i][4]);
		end
		wr(3'h4, 8'h00);
	endtask

	task t_flash;
		logic [7:0]  d;
		logic [31:0] q;
		wr(3'h0, 8'ha5);
		wr(3'h1, 8'h00);
		wr(3'h4, 8'h81);
		rd(3'h2, d);
		chk(d, 8'h3c);
		rd(3'h3, d);
		chk(d, 8'h2b);
		wr(3'h0, 8'h00);
		rd(3'h2, d);
		chk(d, 8'h3c);
		apb(1'b0, 12'h008, 32'h0, q);
		chk(q, 32'h0);
		chk(pslverr, 1'b0);
	endtask

	initial begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		fl_valid = 1'b0;
		fl_addr = 13'h0;
		fl_word = 14'h0;
		num_errors = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		fl_valid <= 1'b1;
		fl_addr <= 13'h00a5;
		fl_word <= 14'h2b3c;
		@(posedge clk);
		fl_valid <= 1'b0;
		@(posedge clk);
		t_write();
		t_refuse();
		t_flash();
		wrap_up();
	end
endmodule // tb_eeprom_write_flash_read_ctrl
